/* File: design/rtc_host_port_pkg.sv */
// Constants for the multiplexed host port and power-on pin logic
package rtc_host_port_pkg;
   localparam int DATA_W = 8;
   localparam int SYNC_STAGES = 2;
   // Control pins beside the bus: latch, select, strobes, power inputs
   localparam int CTRL_PIN_W = 7;
   // Idle levels: latch low, select and strobes high, supply seen absent
   localparam logic [CTRL_PIN_W-1:0] CTRL_PINS_IDLE = 7'h3c;
   // Byte-wide register and RAM space reached through the bus
   localparam int ADDR_W = 8;
   localparam int MEM_DEPTH = 256;
   // Extended control register holding power and crystal bits
   localparam logic [7:0] EXT_CTRL_ADDR = 8'h4b;
   localparam int PWR_HOLD_BIT = 0;
   localparam int PWR_RELEASE_BIT = 1;
   localparam int XTAL_SEL_BIT = 2;
   localparam logic [7:0] EXT_CTRL_RESET = 8'h00;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   // Crystal select encodings
   localparam logic XTAL_6PF = 1'b0;
   localparam logic XTAL_12PF5 = 1'b1;
endpackage

/* File: design/pin_sync.sv */
// Two-stage synchroniser for a group of asynchronous pins
`timescale 1ns/1ns
module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic clk_en,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] meta_next;
   logic [WIDTH-1:0] sync_reg;
   logic [WIDTH-1:0] sync_next;

   // First stage feeds only the second
   always_comb begin
      meta_next = clk_en ? async_in : meta_reg;
      sync_next = clk_en ? meta_reg : sync_reg;
   end

   // Register both stages
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         meta_reg <= INIT;
         sync_reg <= INIT;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end

   assign sync_out = sync_reg;
endmodule // pin_sync

/* File: design/rtc_host_port.sv */
// Multiplexed host bus port, register/RAM store and power-on pin
`timescale 1ns/1ns
// Overview of operation
// - Same eight lines carry address first, then data, each bus cycle.
// - Device drives eight data bits while the read strobe is low.
// - Device releases the bus when the read strobe returns high.
// - The same bus reaches the extended RAM as well as clock registers.
// - Power-on output is active low, open drain, only ever pulls low.
// - Without main supply, kickstart or wake-up asserts power-on output.
// - Once powered, host control bits set the power-on output state.
// - Crystal select bit in register 4B picks 6pF or 12.5pF load.
// - Data moves only with chip select low; a lone latch strobe latches.
// - Address is captured on the falling edge of the latch strobe.
// - Read strobe enables the output buffers; data only while low.
module rtc_host_port #(
   parameter int DEPTH = rtc_host_port_pkg::MEM_DEPTH
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic clk_en,
   input wire logic [rtc_host_port_pkg::DATA_W-1:0] bus_in,
   output logic [rtc_host_port_pkg::DATA_W-1:0] bus_out,
   output logic bus_oe,
   input wire logic addr_latch,
   input wire logic chip_sel_n,
   input wire logic read_n,
   input wire logic write_n,
   input wire logic kickstart_in_n,
   input wire logic wakeup_irq,
   input wire logic main_supply_ok,
   output logic power_on_out_n,
   output logic power_on_oe,
   output logic xtal_load_sel
);
   import rtc_host_port_pkg::*;

   // Refuse a store larger than the byte address reaches
   if (DEPTH < 1 || DEPTH > MEM_DEPTH) begin : g_bad_depth
      $error("DEPTH must lie between 1 and 256");
   end
   // The address is taken straight off the data lines
   if (ADDR_W != DATA_W) begin : g_bad_width
      $error("address and data widths must match");
   end
   // Control bits must sit inside the control byte
   if (XTAL_SEL_BIT >= DATA_W || PWR_HOLD_BIT >= DATA_W ||
       PWR_RELEASE_BIT >= DATA_W) begin : g_bad_bit
      $error("control bit lies outside the control byte");
   end

   // Bus cycle phases
   typedef enum logic [1:0] {IDLE, READING, WRITING} cycle_t;

   // Synchronised pins
   logic [DATA_W-1:0] bus_s;
   logic ale_s;
   logic cs_n_s;
   logic rd_n_s;
   logic wr_n_s;
   logic ks_n_s;
   logic wake_s;
   logic vcc_s;
   // Byte store behind the bus
   logic [DATA_W-1:0] mem [DEPTH];
   // Bus cycle state
   logic ale_prev_reg;
   logic ale_prev_next;
   logic [ADDR_W-1:0] addr_reg;
   logic [ADDR_W-1:0] addr_next;
   logic [DATA_W-1:0] wdata_reg;
   logic [DATA_W-1:0] wdata_next;
   logic [DATA_W-1:0] ext_ctrl_reg;
   logic [DATA_W-1:0] ext_ctrl_next;
   logic [DATA_W-1:0] bus_out_reg;
   logic [DATA_W-1:0] bus_out_next;
   logic bus_oe_reg;
   logic bus_oe_next;
   cycle_t state_reg;
   cycle_t state_next;
   logic mem_we;
   // Power-on state
   logic pwr_on_reg;
   logic pwr_on_next;
   // Strobe decode
   logic ale_fall;
   logic read_req;
   logic write_req;
   logic read_done;
   logic write_done;

   // Address hits the extended control byte
   function automatic logic is_ctrl_addr(input logic [ADDR_W-1:0] a);
      return a == EXT_CTRL_ADDR;
   endfunction

   // Address falls inside the byte store
   function automatic logic in_store(input logic [ADDR_W-1:0] a);
      return int'(a) < DEPTH;
   endfunction

   // Byte read from the store or the extended control register
   function automatic logic [DATA_W-1:0] read_byte(
      input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] ctrl
   );
      logic [DATA_W-1:0] v;
      v = BYTE_ZERO;
      if (is_ctrl_addr(a))
         v = ctrl;
      else if (in_store(a))
         v = mem[a];
      return v;
   endfunction

   // Pins arrive asynchronously
   pin_sync #(
      .WIDTH(DATA_W + CTRL_PIN_W),
      .INIT({DATA_W'(0), CTRL_PINS_IDLE})
   ) u_sync (
      .ref_clk(ref_clk),
      .srst(srst),
      .clk_en(clk_en),
      .async_in({bus_in, addr_latch, chip_sel_n, read_n, write_n,
                 kickstart_in_n, wakeup_irq, main_supply_ok}),
      .sync_out({bus_s, ale_s, cs_n_s, rd_n_s, wr_n_s,
                 ks_n_s, wake_s, vcc_s})
   );

   // Strobe decode on the synchronised pins
   assign ale_fall = ale_prev_reg && !ale_s;
   assign read_req = !cs_n_s && !rd_n_s && !ale_s;
   assign write_req = !cs_n_s && !wr_n_s && !ale_s;
   assign read_done = rd_n_s || cs_n_s;
   assign write_done = wr_n_s || cs_n_s;

   // Bus cycle sequencing and address latch
   always_comb begin
      ale_prev_next = ale_s;
      addr_next = addr_reg;
      wdata_next = wdata_reg;
      state_next = state_reg;
      bus_out_next = bus_out_reg;
      bus_oe_next = 1'b0;
      mem_we = 1'b0;
      ext_ctrl_next = ext_ctrl_reg;
      if (ale_fall)
         addr_next = bus_s;
      case (state_reg)
         IDLE: begin
            if (read_req)
               state_next = READING;
            else if (write_req)
               state_next = WRITING;
         end
         READING: begin
            bus_out_next = read_byte(addr_reg, ext_ctrl_reg);
            bus_oe_next = 1'b1;
            if (read_done) begin
               state_next = IDLE;
               bus_oe_next = 1'b0;
            end
         end
         WRITING: begin
            // Keep the latest value seen while the strobe is low
            wdata_next = bus_s;
            if (write_done) begin
               state_next = IDLE;
               if (is_ctrl_addr(addr_reg))
                  ext_ctrl_next = wdata_reg;
               else
                  mem_we = 1'b1;
            end
         end
         default: state_next = IDLE;
      endcase
   end

   // Power-on pin control
   always_comb begin
      pwr_on_next = pwr_on_reg;
      if (!vcc_s) begin
         if (!ks_n_s || wake_s)
            pwr_on_next = 1'b1;
      end else if (ext_ctrl_reg[PWR_RELEASE_BIT]) begin
         pwr_on_next = 1'b0;
      end else if (ext_ctrl_reg[PWR_HOLD_BIT]) begin
         pwr_on_next = 1'b1;
      end
   end

   // State registers
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ale_prev_reg <= 1'b0;
         addr_reg <= '0;
         wdata_reg <= '0;
         state_reg <= IDLE;
         bus_out_reg <= '0;
         bus_oe_reg <= 1'b0;
         ext_ctrl_reg <= EXT_CTRL_RESET;
         pwr_on_reg <= 1'b0;
      end else if (clk_en) begin
         ale_prev_reg <= ale_prev_next;
         addr_reg <= addr_next;
         wdata_reg <= wdata_next;
         state_reg <= state_next;
         bus_out_reg <= bus_out_next;
         bus_oe_reg <= bus_oe_next;
         ext_ctrl_reg <= ext_ctrl_next;
         pwr_on_reg <= pwr_on_next;
      end
   end

   // Register and RAM store
   always_ff @(posedge ref_clk) begin
      if (clk_en && !srst && mem_we && in_store(addr_reg))
         mem[addr_reg] <= wdata_reg;
   end

   // Outputs straight from registers; power_on_out_n tied low
   assign bus_out = bus_out_reg;
   assign bus_oe = bus_oe_reg;
   assign power_on_out_n = 1'b0;
   assign power_on_oe = pwr_on_reg;
   assign xtal_load_sel = ext_ctrl_reg[XTAL_SEL_BIT];
endmodule // rtc_host_port

/* File: verif/rtc_host_port_asserts.sv */
// Checker on the host port pins
`timescale 1ns/1ns
module rtc_host_port_asserts (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic read_n,
   input wire logic chip_sel_n,
   input wire logic kickstart_in_n,
   input wire logic main_supply_ok,
   input wire logic [7:0] bus_out,
   input wire logic bus_oe,
   input wire logic power_on_out_n,
   input wire logic power_on_oe
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   oe_in_read_a: assert property (bus_oe |->
      !$past(read_n, 4) && !$past(chip_sel_n, 4)) else $error("stray drive");
   oe_release_a: assert property ($rose(read_n) |->
      ##[1:5] !bus_oe) else $error("no release");
   read_drive_a: assert property ((!read_n && !chip_sel_n)[*6] |->
      bus_oe) else $error("no read drive");
   cs_gate_a: assert property (chip_sel_n[*5] |-> !bus_oe)
      else $error("drive without select");
   rd_gate_a: assert property (read_n[*5] |-> !bus_oe)
      else $error("drive without read");
   data_hold_a: assert property (bus_oe && $past(bus_oe) |->
      $stable(bus_out)) else $error("data moved");
   open_drain_a: assert property (power_on_out_n == 1'b0)
      else $error("pin driven high");
   kick_on_a: assert property (
      (!main_supply_ok && !kickstart_in_n)[*5] |-> power_on_oe)
      else $error("no power on");
endmodule // rtc_host_port_asserts
bind rtc_host_port rtc_host_port_asserts u_asserts (.*);

/* File: verif/host_bus_model.sv */
// Host model for the shared address/data bus
`timescale 1ns/1ns
module host_bus_model (
   input wire logic ref_clk,
   input wire logic [7:0] bus_out,
   input wire logic bus_oe,
   output logic [7:0] bus_in,
   output logic addr_latch,
   output logic chip_sel_n,
   output logic read_n,
   output logic write_n
);
   logic [7:0] hd, last;
   logic drv;
   // Wire level; a released bus keeps changing
   assign bus_in = bus_oe ? bus_out : drv ? hd : ~last;
   always @(posedge ref_clk) last <= bus_in;
   initial {drv, hd, last, addr_latch, chip_sel_n, read_n, write_n} = 21'h7;
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   // One byte: address phase, then data phase
   task automatic xfer(input logic rd, input logic sel,
      input logic [7:0] a, input logic [7:0] wd, output logic [7:0] q);
      q = 8'h00;
      tick(1);
      {drv, hd, addr_latch} = {1'b1, a, 1'b1};
      tick(4);
      addr_latch = 1'b0;
      tick(4);
      chip_sel_n = ~sel;
      if (rd) begin
         {drv, read_n} = 2'h0;
         tick(8);
         q = bus_in;
      end else begin
         {hd, write_n} = {wd, 1'b0};
         tick(6);
         write_n = 1'b1;
         tick(3);
      end
      {drv, chip_sel_n, read_n} = 3'h3;
      tick(5);
   endtask
endmodule // host_bus_model

/* File: verif/tb_rtc_muxed_host_bus_and_power_pin.sv */
// Self-checking bench for the host port
`timescale 1ns/1ns
module tb_rtc_muxed_host_bus_and_power_pin;
   import rtc_host_port_pkg::*;
   logic ref_clk = 1'b0, srst = 1'b1, kickstart_in_n = 1'b1;
   logic wakeup_irq = 1'b0, main_supply_ok = 1'b1;
   logic bus_oe, addr_latch, chip_sel_n, read_n, write_n;
   logic power_on_out_n, power_on_oe, xtal_load_sel;
   logic [7:0] bus_in, bus_out, q;
   int err_total = 0, checked = 0;
   always #4 ref_clk = ~ref_clk;
   rtc_host_port dut (.clk_en(1'b1), .*);
   host_bus_model host (.*);
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      if (err_total == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Bounded wait on the power-on pin
   task automatic pwr_is(input logic e);
      int n;
      for (n = 0; n < 20 && power_on_oe !== e; n++) host.tick(1);
      chk({7'h00, power_on_oe}, {7'h00, e});
      if (n == 20) tally_and_finish();
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host.xfer(1'b0, 1'b1, a, d, q);
   endtask
   // RAM bytes; an unselected write moves nothing
   task automatic t_mem();
      wr(8'h10, 8'ha5);
      wr(8'hf0, 8'h3c);
      host.xfer(1'b0, 1'b0, 8'h10, 8'h5a, q);
      host.xfer(1'b1, 1'b1, 8'h10, 8'h00, q);
      chk(q, 8'ha5);
      host.xfer(1'b1, 1'b1, 8'hf0, 8'h00, q);
      chk(q, 8'h3c);
      chk({7'h00, bus_oe}, 8'h00);
   endtask
   // Crystal select and power pin control
   task automatic t_pwr();
      wr(EXT_CTRL_ADDR, 8'h01 << XTAL_SEL_BIT);
      chk({7'h00, xtal_load_sel}, {7'h00, XTAL_12PF5});
      host.xfer(1'b1, 1'b1, EXT_CTRL_ADDR, BYTE_ZERO, q);
      chk(q, 8'h01 << XTAL_SEL_BIT);
      wr(EXT_CTRL_ADDR, BYTE_ZERO);
      chk({7'h00, xtal_load_sel}, {7'h00, XTAL_6PF});
      {main_supply_ok, kickstart_in_n} = 2'h0;
      pwr_is(1'b1);
      host.tick(4); // Kickstart held long enough for the checker
      {main_supply_ok, kickstart_in_n} = 2'h3;
      wr(EXT_CTRL_ADDR, 8'h01 << PWR_RELEASE_BIT);
      pwr_is(1'b0);
      wr(EXT_CTRL_ADDR, 8'h01 << PWR_HOLD_BIT);
      pwr_is(1'b1);
      wr(EXT_CTRL_ADDR, 8'h01 << PWR_RELEASE_BIT);
      pwr_is(1'b0);
      {main_supply_ok, wakeup_irq} = 2'h1;
      pwr_is(1'b1);
      chk({7'h00, power_on_out_n}, 8'h00);
   endtask
   initial begin
      repeat (5) @(posedge ref_clk);
      #1;
      srst = 1'b0;
      t_mem();
      t_pwr();
      tally_and_finish();
   end
endmodule // tb_rtc_muxed_host_bus_and_power_pin
